// [param_latch_params.svh]
// Purpose: named constants for the parameter access and fault latch block
// Assumes: included by bare name; definitions only
// Notes:   fault codes are 16-bit values as shown on the diagnostic word
`ifndef PARAM_LATCH_PARAMS_SVH
`define PARAM_LATCH_PARAMS_SVH

`define FC_RT_ALERT      16'hb602
`define FC_PROTO_ERR     16'hb603
`define FC_PROTO_ALERT   16'hb604
`define FC_UNKNOWN       16'hb605
`define FC_BUSY          16'hb607
`define FC_HOT_RESET     16'hb608
`define FC_HOT_STOP      16'hb609
`define FC_INT_TIMEOUT   16'hb60a
`define FC_INT_ERR       16'hb60b
`define FC_INCOMPAT      16'hb60c

`define CLASS_0          3'h0
`define CLASS_2          3'h2
`define CLASS_4          3'h4

`define WARN_ETH_BIT     4'he
`define SIG_ETH_BIT      4'h8
`define CLASS_BITS       5

`define NUM_PARAMS       16
`define ADDR_W           4
`define ZERO_WORD        32'h0000_0000
`define ZERO_HALF        16'h0000

// data type limits
`define S8_MIN           32'hffff_ff80
`define S8_MAX           32'h0000_007f
`define U8_MAX           32'h0000_00ff
`define S16_MIN          32'hffff_8000
`define S16_MAX          32'h0000_7fff
`define U16_MAX          32'h0000_ffff
`define S32_MIN          32'h8000_0000
`define S32_MAX          32'h7fff_ffff
`define U32_MAX          32'hffff_ffff

`endif

// [param_latch_pkg.sv]
// Purpose: types for the parameter access and fault latch block
// Assumes: constants come from param_latch_params.svh
// Notes:   parameter attributes travel as one packed struct
package param_latch_pkg;

  typedef enum logic [2:0] {
    DT_INT8,
    DT_UINT8,
    DT_INT16,
    DT_UINT16,
    DT_INT32,
    DT_UINT32
  } data_type_t;

  typedef struct packed {
    data_type_t  dtype;
    logic        writable;
    logic        persistent;
    logic        expert;
    logic        restart_apply;
    logic        has_limits;
    logic [31:0] min_val;
    logic [31:0] max_val;
  } param_attr_t;

  typedef struct packed {
    logic rt_alert;
    logic link_fault;
    logic proto_alert;
    logic unknown_fault;
    logic int_timeout;
    logic int_error;
    logic incompat;
    logic chan_reset;
  } eth_events_t;

  typedef enum logic [1:0] {
    ACC_OK,
    ACC_READ_ONLY,
    ACC_EXPERT,
    ACC_RANGE
  } access_status_t;

endpackage : param_latch_pkg

// [param_store.sv]
// Purpose: small parameter memory with registered read data
// Assumes: one write port and one read port on the drive clock
// Notes:   contents are cleared by reset
`timescale 1ns/1ps
`default_nettype none
`include "param_latch_params.svh"

module param_store (
  input  wire logic                 ref_clk_i, // drive clock
  input  wire logic                 srst_i,    // sync reset
  input  wire logic                 we_i,      // write strobe
  input  wire logic [`ADDR_W-1:0]   waddr_i,   // write address
  input  wire logic [31:0]          wdata_i,   // write data
  input  wire logic [`ADDR_W-1:0]   raddr_i,   // read address
  output logic      [31:0]          rdata_o    // registered read data
);

  logic [31:0] mem [`NUM_PARAMS];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < `NUM_PARAMS; i++) begin
        mem[i] <= `ZERO_WORD;
      end
    end else if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= `ZERO_WORD;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : param_store

`default_nettype wire

// [param_access_latch.sv]
// Purpose: parameter write checking and ethernet fault latching
// Assumes: request and event inputs come from logic on ref_clk_i
// Notes:   values are scaled integers; the master stores persistent data
`timescale 1ns/1ps
`default_nettype none
`include "param_latch_params.svh"

// Overview of operation
// - realtime alert gives b602, class 0, warn 14
// - link timeout gives b603, class 2, sig 8
// - protocol alert gives b604, class 0, warn 14
// - unclassified fault gives b605, class 2, sig 8
// - request while busy gives b607, warn 14
// - channel reset while enabled gives b608, sig 8
// - internal timeout gives b60a, class 0, warn 14
// - internal error gives b60b, class 0, warn 14
// - incompatible firmware gives b60c, class 4, sig 8
// - no explicit limits means data type limits
// - reject writes outside minimum or maximum
// - read-only parameters readable, never written
// - read-write parameters accept reads and writes
// - expert parameters writable only in expert mode
// - each parameter selected by its own address
// - fractional values travel as scaled integers
// - some parameters take effect after restart; restart applies only the value pending at the last request address
// - action status bits 0-4 show classes
module param_access_latch (
  input  wire logic                         ref_clk_i,    // drive clock
  input  wire logic                         srst_i,       // sync reset
  input  wire logic                         req_i,        // access request
  input  wire logic                         req_write_i,  // 1 write, 0 read
  input  wire logic [`ADDR_W-1:0]           req_addr_i,   // parameter addr
  input  wire logic [31:0]                  req_data_i,   // scaled value
  input  wire param_latch_pkg::param_attr_t attr_i,       // attrs of addr
  input  wire logic                         expert_i,     // expert active
  input  wire logic                         power_en_i,   // power stage on
  input  wire logic                         restart_i,    // restart pulse
  input  wire logic                         store_req_i,  // store request
  input  wire param_latch_pkg::eth_events_t eth_evt_i,    // fault pulses
  input  wire logic                         warn_clr_i,   // clear warnings
  input  wire logic                         sig_clr_i,    // clear errors
  output logic                              ack_o,        // access done
  output logic [31:0]                       rdata_o,      // read value
  output param_latch_pkg::access_status_t   status_o,     // access result
  output logic                              store_o,      // nv store pulse
  output logic [15:0]                       fault_code_o, // last fault
  output logic [2:0]                        fault_class_o,// its class
  output logic [15:0]                       warning_latch_word_o,      // w
  output logic [15:0]                       error_signal_latch_word_o, // e
  output logic [15:0]                       action_status_word_o       // a
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_DONE
  } acc_state_t;

  acc_state_t                      state;
  acc_state_t                      next_state;
  param_latch_pkg::access_status_t next_status;
  logic                            next_we;
  logic [31:0]                     lo_lim;
  logic [31:0]                     hi_lim;
  logic                            signed_cmp;
  logic                            in_range;
  logic                            busy_evt;
  logic                            hot_reset_evt;
  logic [31:0]                     store_rdata;
  logic [`ADDR_W-1:0]              addr;
  logic [`NUM_PARAMS-1:0]          pend_valid;
  logic [31:0]                     pend_data [`NUM_PARAMS];
  logic                            pend_we;
  logic [15:0]                     next_code;
  logic [2:0]                      next_class;
  logic                            evt_any;
  logic [`CLASS_BITS-1:0]          class_seen;
  logic                            warn_set;
  logic                            sig_set;

  // explicit bounds, else the data type bounds
  always_comb begin
    signed_cmp = 1'b0;
    lo_lim     = `ZERO_WORD;
    hi_lim     = `U32_MAX;
    case (attr_i.dtype)
      param_latch_pkg::DT_INT8: begin
        signed_cmp = 1'b1;
        lo_lim     = `S8_MIN;
        hi_lim     = `S8_MAX;
      end
      param_latch_pkg::DT_UINT8: begin
        hi_lim     = `U8_MAX;
      end
      param_latch_pkg::DT_INT16: begin
        signed_cmp = 1'b1;
        lo_lim     = `S16_MIN;
        hi_lim     = `S16_MAX;
      end
      param_latch_pkg::DT_UINT16: begin
        hi_lim     = `U16_MAX;
      end
      param_latch_pkg::DT_INT32: begin
        signed_cmp = 1'b1;
        lo_lim     = `S32_MIN;
        hi_lim     = `S32_MAX;
      end
      default: begin
        hi_lim     = `U32_MAX;
      end
    endcase
    if (attr_i.has_limits) begin
      lo_lim = attr_i.min_val;
      hi_lim = attr_i.max_val;
    end
  end

  // data arrives pre-scaled by its decimal places
  always_comb begin
    if (signed_cmp) begin
      in_range = ($signed(req_data_i) >= $signed(lo_lim)) &&
                 ($signed(req_data_i) <= $signed(hi_lim));
    end else begin
      in_range = (req_data_i >= lo_lim) && (req_data_i <= hi_lim);
    end
  end

  // refusal order: attribute, expert, range
  always_comb begin
    next_status = param_latch_pkg::ACC_OK;
    next_we     = 1'b0;
    pend_we     = 1'b0;
    if (req_write_i) begin
      if (!attr_i.writable) begin
        next_status = param_latch_pkg::ACC_READ_ONLY;
      end else if (attr_i.expert && !expert_i) begin
        next_status = param_latch_pkg::ACC_EXPERT;
      end else if (!in_range) begin
        next_status = param_latch_pkg::ACC_RANGE;
      end else if (attr_i.restart_apply) begin
        pend_we     = 1'b1;
      end else begin
        next_we     = 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_i && !req_write_i) begin
          next_state = ST_READ;
        end else if (req_i) begin
          next_state = ST_DONE;
        end
      end
      ST_READ: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      addr <= '0;
    end else if (state == ST_IDLE && req_i) begin
      addr <= req_addr_i;
    end
  end

  // a request outside idle is refused as busy
  assign busy_evt = req_i && (state != ST_IDLE);
  assign hot_reset_evt = eth_evt_i.chan_reset && power_en_i;

  param_store u_store (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .we_i      ((state == ST_IDLE && req_i && next_we) ||
                (restart_i && pend_valid[addr])),
    .waddr_i   (restart_i ? addr : req_addr_i),
    .wdata_i   (restart_i ? pend_data[addr] : req_data_i),
    .raddr_i   (req_addr_i),
    .rdata_o   (store_rdata)
  );

  // deferred values wait here until restart
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pend_valid <= '0;
      for (int i = 0; i < `NUM_PARAMS; i++) begin
        pend_data[i] <= `ZERO_WORD;
      end
    end else if (restart_i) begin
      pend_valid <= '0;
    end else if (state == ST_IDLE && req_i && pend_we) begin
      pend_valid[req_addr_i] <= 1'b1;
      pend_data[req_addr_i]  <= req_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ack_o    <= 1'b0;
      status_o <= param_latch_pkg::ACC_OK;
      rdata_o  <= `ZERO_WORD;
    end else begin
      ack_o <= 1'b0;
      if (state == ST_IDLE && req_i) begin
        status_o <= next_status;
        ack_o    <= req_write_i;
      end else if (state == ST_READ) begin
        rdata_o <= store_rdata;
        ack_o   <= 1'b1;
      end
    end
  end

  // nv copy only on the master's store request
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      store_o <= 1'b0;
    end else begin
      store_o <= store_req_i;
    end
  end

  // first listed event wins the code
  always_comb begin
    next_code  = fault_code_o;
    next_class = fault_class_o;
    evt_any    = 1'b1;
    if (eth_evt_i.incompat) begin
      next_code  = `FC_INCOMPAT;
      next_class = `CLASS_4;
    end else if (hot_reset_evt) begin
      next_code  = `FC_HOT_RESET;
      next_class = `CLASS_2;
    end else if (eth_evt_i.link_fault) begin
      next_code  = `FC_PROTO_ERR;
      next_class = `CLASS_2;
    end else if (eth_evt_i.unknown_fault) begin
      next_code  = `FC_UNKNOWN;
      next_class = `CLASS_2;
    end else if (eth_evt_i.rt_alert) begin
      next_code  = `FC_RT_ALERT;
      next_class = `CLASS_0;
    end else if (eth_evt_i.proto_alert) begin
      next_code  = `FC_PROTO_ALERT;
      next_class = `CLASS_0;
    end else if (busy_evt) begin
      next_code  = `FC_BUSY;
      next_class = `CLASS_0;
    end else if (eth_evt_i.int_timeout) begin
      next_code  = `FC_INT_TIMEOUT;
      next_class = `CLASS_0;
    end else if (eth_evt_i.int_error) begin
      next_code  = `FC_INT_ERR;
      next_class = `CLASS_0;
    end else begin
      evt_any    = 1'b0;
    end
  end

  assign warn_set = eth_evt_i.rt_alert || eth_evt_i.proto_alert ||
                    busy_evt || eth_evt_i.int_timeout ||
                    eth_evt_i.int_error;
  assign sig_set  = eth_evt_i.link_fault || eth_evt_i.unknown_fault ||
                    hot_reset_evt || eth_evt_i.incompat;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      fault_code_o  <= `ZERO_HALF;
      fault_class_o <= `CLASS_0;
    end else if (evt_any) begin
      fault_code_o  <= next_code;
      fault_class_o <= next_class;
    end
  end

  // set beats clear in the same cycle so no event is lost
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      warning_latch_word_o <= `ZERO_HALF;
    end else if (warn_set) begin
      warning_latch_word_o[`WARN_ETH_BIT] <= 1'b1;
    end else if (warn_clr_i) begin
      warning_latch_word_o <= `ZERO_HALF;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      error_signal_latch_word_o <= `ZERO_HALF;
    end else if (sig_set) begin
      error_signal_latch_word_o[`SIG_ETH_BIT] <= 1'b1;
    end else if (sig_clr_i) begin
      error_signal_latch_word_o <= `ZERO_HALF;
    end
  end

  // class bits track the latches
  always_comb begin
    class_seen    = action_status_word_o[`CLASS_BITS-1:0];
    if (warn_set) begin
      class_seen[`CLASS_0] = 1'b1;
    end
    if (eth_evt_i.link_fault || eth_evt_i.unknown_fault || hot_reset_evt) begin
      class_seen[`CLASS_2] = 1'b1;
    end
    if (eth_evt_i.incompat) begin
      class_seen[`CLASS_4] = 1'b1;
    end
    if (warn_clr_i && !warn_set) begin
      class_seen[`CLASS_0] = 1'b0;
    end
    if (sig_clr_i && !sig_set) begin
      class_seen[`CLASS_2] = 1'b0;
      class_seen[`CLASS_4] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      action_status_word_o <= `ZERO_HALF;
    end else begin
      action_status_word_o[`CLASS_BITS-1:0] <= class_seen;
    end
  end

endmodule : param_access_latch

`default_nettype wire

// [param_latch_properties.sv]
// Purpose: concurrent checks on parameter access and fault latching
// Assumes: one clock domain, synchronous active-high reset
// Notes:   refusals rank read-only, expert, range
`timescale 1ns/1ps
`default_nettype none
`include "param_latch_params.svh"

module param_latch_properties (
  input wire logic                         ref_clk_i,     // clock
  input wire logic                         srst_i,        // reset
  input wire logic                         req_i,         // request
  input wire logic                         req_write_i,   // write
  input wire logic [31:0]                  req_data_i,    // value
  input wire param_latch_pkg::param_attr_t attr_i,        // attrs
  input wire logic                         expert_i,      // expert
  input wire logic                         power_en_i,    // power on
  input wire logic                         store_req_i,   // store req
  input wire param_latch_pkg::eth_events_t eth_evt_i,     // events
  input wire logic                         warn_clr_i,    // clr warn
  input wire logic                         sig_clr_i,     // clr sig
  input wire logic                         ack_o,         // done
  input wire param_latch_pkg::access_status_t status_o,   // result
  input wire logic                         store_o,       // store
  input wire logic [15:0]                  fault_code_o,  // code
  input wire logic [2:0]                   fault_class_o, // class
  input wire logic [15:0]                  warning_latch_word_o,
  input wire logic [15:0]                  error_signal_latch_word_o,
  input wire logic [15:0]                  action_status_word_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // one quiet cycle finds the block idle after a write; after a read it takes two
  sequence s_idle;
    !req_i;
  endsequence
  sequence s_wr;
    s_idle ##1 (req_i && req_write_i && attr_i.writable);
  endsequence
  sequence s_plain_wr;
    s_wr ##0 (!attr_i.expert || expert_i);
  endsequence

  // busy requests compete, so none here
  property p_evt(logic [7:0] m, logic [15:0] c, logic [2:0] k, logic w);
    !req_i && power_en_i && eth_evt_i == m |=> fault_code_o == c &&
      fault_class_o == k &&
      (w ? warning_latch_word_o[14] : error_signal_latch_word_o[8]);
  endproperty

  chk_rt_alert: assert property (p_evt(8'h80, 16'hb602, 3'h0, 1'h1))
    else $error("rt alert lost");
  chk_link_fault: assert property (p_evt(8'h40, 16'hb603, 3'h2, 1'h0))
    else $error("link fault lost");
  chk_proto_alert: assert property (p_evt(8'h20, 16'hb604, 3'h0, 1'h1))
    else $error("proto alert lost");
  chk_unknown_fault: assert property (p_evt(8'h10, 16'hb605, 3'h2, 1'h0))
    else $error("unknown fault lost");
  chk_hot_reset: assert property (p_evt(8'h01, 16'hb608, 3'h2, 1'h0))
    else $error("hot reset lost");
  chk_int_timeout: assert property (p_evt(8'h08, 16'hb60a, 3'h0, 1'h1))
    else $error("int timeout lost");
  chk_int_error: assert property (p_evt(8'h04, 16'hb60b, 3'h0, 1'h1))
    else $error("int error lost");
  chk_fw_incompat: assert property (p_evt(8'h02, 16'hb60c, 3'h4, 1'h0))
    else $error("incompat lost");
  chk_busy_warn: assert property (
    s_idle ##1 (req_i && req_write_i) ##1 (req_i && eth_evt_i == 8'h00)
    |=> fault_code_o == 16'hb607 && warning_latch_word_o[14] && !ack_o)
    else $error("busy not flagged");
  chk_type_range: assert property (s_plain_wr ##0 (!attr_i.has_limits &&
    attr_i.dtype == param_latch_pkg::DT_UINT16 && req_data_i > 32'hffff)
    |=> status_o == param_latch_pkg::ACC_RANGE)
    else $error("type range open");
  chk_limit_range: assert property (s_plain_wr ##0 (attr_i.has_limits &&
    attr_i.dtype == param_latch_pkg::DT_INT16 &&
    ($signed(req_data_i) > $signed(attr_i.max_val) ||
     $signed(req_data_i) < $signed(attr_i.min_val)))
    |=> status_o == param_latch_pkg::ACC_RANGE)
    else $error("limits open");
  chk_read_only: assert property (
    s_idle ##1 (req_i && req_write_i && !attr_i.writable)
    |=> ack_o && status_o == param_latch_pkg::ACC_READ_ONLY)
    else $error("read-only written");
  chk_expert_lock: assert property (
    s_wr ##0 (attr_i.expert && !expert_i)
    |=> status_o == param_latch_pkg::ACC_EXPERT)
    else $error("expert written");
  chk_write_ack: assert property (s_idle ##1 (req_i && req_write_i)
    |=> ack_o ##1 !ack_o)
    else $error("write ack late");
  chk_read_ack: assert property (s_idle ##1 (req_i && !req_write_i)
    |=> !ack_o ##1 ack_o)
    else $error("read ack late");
  chk_store_pulse: assert property (store_req_i |=> store_o ##1 !store_o)
    else $error("store pulse wrong");
  chk_action_class: assert property (action_status_word_o[15:5] == 11'h0 &&
    !action_status_word_o[1] && !action_status_word_o[3] &&
    action_status_word_o[0] == warning_latch_word_o[14] &&
    (action_status_word_o[2] || action_status_word_o[4]) ==
      error_signal_latch_word_o[8])
    else $error("action word wrong");
  chk_warn_sticky: assert property (warning_latch_word_o[14] &&
    !warn_clr_i |=> warning_latch_word_o[14])
    else $error("warn latch dropped");
  chk_sig_sticky: assert property (error_signal_latch_word_o[8] &&
    !sig_clr_i |=> error_signal_latch_word_o[8])
    else $error("error latch dropped");
endmodule : param_latch_properties

bind param_access_latch param_latch_properties u_props (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req_i),
  .req_write_i(req_write_i), .req_data_i(req_data_i), .attr_i(attr_i),
  .expert_i(expert_i), .power_en_i(power_en_i), .store_req_i(store_req_i),
  .eth_evt_i(eth_evt_i), .warn_clr_i(warn_clr_i), .sig_clr_i(sig_clr_i),
  .ack_o(ack_o), .status_o(status_o), .store_o(store_o),
  .fault_code_o(fault_code_o), .fault_class_o(fault_class_o),
  .warning_latch_word_o(warning_latch_word_o),
  .error_signal_latch_word_o(error_signal_latch_word_o),
  .action_status_word_o(action_status_word_o));
`default_nettype wire

// [master_model.sv]
// Purpose: fieldbus master side: parameter attributes and store requests
// Assumes: request signals are stable at the rising edge
// Notes:   attributes follow the address at all times
`timescale 1ns/1ps
`default_nettype none

module master_model (
  input  wire logic                            ref_clk_i,   // clock
  input  wire logic [3:0]                      addr_i,      // address
  input  wire logic                            req_i,       // request
  input  wire logic                            write_i,     // write
  input  wire logic                            ack_i,       // done
  input  wire param_latch_pkg::access_status_t status_i,    // result
  output var  param_latch_pkg::param_attr_t    attr_o,      // attrs
  output var  logic                            store_req_o  // store
);
  logic pers_wr;

  always_comb begin
    attr_o = '0;
    attr_o.writable = 1'h1;
    attr_o.dtype = param_latch_pkg::DT_UINT32;
    case (addr_i)
      4'h0: attr_o.dtype = param_latch_pkg::DT_UINT16;
      4'h1: attr_o.dtype = param_latch_pkg::DT_INT16;
      4'h2: begin
        attr_o.dtype = param_latch_pkg::DT_INT16;
        attr_o.has_limits = 1'h1;
        attr_o.min_val = 32'hffff_fffc;
        attr_o.max_val = 32'h0000_0006;
      end
      4'h3: attr_o.writable = 1'h0;
      4'h4: attr_o.expert = 1'h1;
      4'h5: attr_o.restart_apply = 1'h1;
      4'h6: attr_o.persistent = 1'h1;
      default: ;
    endcase
  end

  always @(posedge ref_clk_i) begin
    if (req_i && write_i) begin
      pers_wr <= attr_o.persistent;
    end
  end
  // persistence needs an explicit store request
  always @(negedge ref_clk_i) begin
    store_req_o <= ack_i && pers_wr &&
      status_i == param_latch_pkg::ACC_OK;
  end
endmodule : master_model
`default_nettype wire

// [testbench.sv]
// Purpose: directed test of parameter access and fault latching
// Assumes: inputs driven at the falling edge
// Notes:   values are scaled integers, e.g. 23.57 sent as 2357
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) begin \
      n_errors++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (e)); \
    end \
  end

module testbench;
  logic ref_clk_i, srst_i, req_i, req_write_i, expert_i, power_en_i;
  logic restart_i, store_req_i, warn_clr_i, sig_clr_i, ack_o, store_o;
  logic [3:0] req_addr_i;
  logic [31:0] req_data_i, rdata_o;
  logic [15:0] fault_code_o, warning_latch_word_o;
  logic [15:0] error_signal_latch_word_o, action_status_word_o;
  logic [2:0] fault_class_o;
  param_latch_pkg::param_attr_t attr_i;
  param_latch_pkg::eth_events_t eth_evt_i;
  param_latch_pkg::access_status_t status_o;
  int n_errors, checked, cycles, n_store;

  param_access_latch u_dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .req_i(req_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_data_i(req_data_i), .attr_i(attr_i), .expert_i(expert_i),
    .power_en_i(power_en_i), .restart_i(restart_i),
    .store_req_i(store_req_i), .eth_evt_i(eth_evt_i),
    .warn_clr_i(warn_clr_i), .sig_clr_i(sig_clr_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .status_o(status_o), .store_o(store_o),
    .fault_code_o(fault_code_o), .fault_class_o(fault_class_o),
    .warning_latch_word_o(warning_latch_word_o),
    .error_signal_latch_word_o(error_signal_latch_word_o),
    .action_status_word_o(action_status_word_o));

  master_model u_master (
    .ref_clk_i(ref_clk_i), .addr_i(req_addr_i), .req_i(req_i),
    .write_i(req_write_i), .ack_i(ack_o), .status_i(status_o),
    .attr_o(attr_i), .store_req_o(store_req_i));

  initial begin
    ref_clk_i = 1'h0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic close_out();
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end
  always @(negedge ref_clk_i) begin
    if (store_o === 1'h1) begin
      n_store++;
    end
  end

  task automatic put(input logic [3:0] a, input logic [31:0] d,
                     input logic w);
    req_i = 1'h1;
    req_write_i = w;
    req_addr_i = a;
    req_data_i = d;
  endtask : put

  // writes come every two cycles, reads every three
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input param_latch_pkg::access_status_t s);
    put(a, d, 1'h1);
    @(negedge ref_clk_i);
    req_i = 1'h0;
    `CHK(ack_o, 1'h1)
    `CHK(status_o, s)
    @(negedge ref_clk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] d);
    put(a, 32'h0, 1'h0);
    @(negedge ref_clk_i);
    req_i = 1'h0;
    @(negedge ref_clk_i);
    `CHK(ack_o, 1'h1)
    `CHK(rdata_o, d)
    @(negedge ref_clk_i);
  endtask : rd

  task automatic ev(input logic [7:0] m, input logic [15:0] c,
                    input logic [2:0] k, input logic w);
    eth_evt_i = param_latch_pkg::eth_events_t'(m);
    @(negedge ref_clk_i);
    eth_evt_i = '0;
    `CHK(fault_code_o, c)
    `CHK(fault_class_o, k)
    `CHK(w ? warning_latch_word_o : error_signal_latch_word_o,
         w ? 16'h4000 : 16'h0100)
    @(negedge ref_clk_i);
  endtask : ev

  initial begin
    srst_i = 1'h1;
    {req_i, req_write_i, expert_i, power_en_i, restart_i} = 5'h00;
    {warn_clr_i, sig_clr_i, req_addr_i, req_data_i} = '0;
    eth_evt_i = '0;
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'h0;
    `CHK(warning_latch_word_o, 16'h0)
    `CHK(action_status_word_o, 16'h0)
    wr(4'h0, 32'hffff, param_latch_pkg::ACC_OK);
    wr(4'h0, 32'h1_0000, param_latch_pkg::ACC_RANGE);
    wr(4'h1, 32'hffff_8000, param_latch_pkg::ACC_OK);
    wr(4'h1, 32'hffff_7fff, param_latch_pkg::ACC_RANGE);
    wr(4'h1, 32'h8000, param_latch_pkg::ACC_RANGE);
    wr(4'h2, 32'h6, param_latch_pkg::ACC_OK);
    wr(4'h2, 32'h7, param_latch_pkg::ACC_RANGE);
    wr(4'h2, 32'hffff_fffc, param_latch_pkg::ACC_OK);
    wr(4'h2, 32'hffff_fffb, param_latch_pkg::ACC_RANGE);
    wr(4'h3, 32'h1, param_latch_pkg::ACC_READ_ONLY);
    wr(4'h4, 32'h5, param_latch_pkg::ACC_EXPERT);
    expert_i = 1'h1;
    wr(4'h4, 32'h5, param_latch_pkg::ACC_OK);
    wr(4'h5, 32'h2357, param_latch_pkg::ACC_OK);
    rd(4'h0, 32'hffff);
    rd(4'h1, 32'hffff_8000);
    rd(4'h2, 32'hffff_fffc);
    rd(4'h3, 32'h0);
    rd(4'h4, 32'h5);
    rd(4'h5, 32'h0);
    restart_i = 1'h1;
    @(negedge ref_clk_i);
    restart_i = 1'h0;
    rd(4'h5, 32'h2357);
    wr(4'h6, 32'h32, param_latch_pkg::ACC_OK);
    repeat (2) @(negedge ref_clk_i);
    `CHK(n_store, 1)
    put(4'h0, 32'h1, 1'h1);
    repeat (2) @(negedge ref_clk_i);
    req_i = 1'h0;
    `CHK(ack_o, 1'h0)
    `CHK(fault_code_o, 16'hb607)
    `CHK(warning_latch_word_o, 16'h4000)
    {power_en_i, warn_clr_i} = 2'h3;
    @(negedge ref_clk_i);
    warn_clr_i = 1'h0;
    ev(8'h80, 16'hb602, 3'h0, 1'h1);
    ev(8'h40, 16'hb603, 3'h2, 1'h0);
    ev(8'h20, 16'hb604, 3'h0, 1'h1);
    ev(8'h10, 16'hb605, 3'h2, 1'h0);
    ev(8'h08, 16'hb60a, 3'h0, 1'h1);
    ev(8'h04, 16'hb60b, 3'h0, 1'h1);
    ev(8'h02, 16'hb60c, 3'h4, 1'h0);
    power_en_i = 1'h0;
    ev(8'h01, 16'hb60c, 3'h4, 1'h0);
    power_en_i = 1'h1;
    ev(8'h01, 16'hb608, 3'h2, 1'h0);
    `CHK(action_status_word_o, 16'h0015)
    repeat (3) @(negedge ref_clk_i);
    `CHK(warning_latch_word_o, 16'h4000)
    warn_clr_i = 1'h1;
    @(negedge ref_clk_i);
    warn_clr_i = 1'h0;
    `CHK(warning_latch_word_o, 16'h0)
    `CHK(action_status_word_o, 16'h0014)
    sig_clr_i = 1'h1;
    @(negedge ref_clk_i);
    sig_clr_i = 1'h0;
    `CHK(error_signal_latch_word_o, 16'h0)
    `CHK(action_status_word_o, 16'h0)
    close_out();
  end
endmodule : testbench
`default_nettype wire
